// >>> rtl/sbst_defines.svh
`ifndef SBST_DEFINES_SVH
`define SBST_DEFINES_SVH

// register lengths
`define SBST_IR_W       3
`define SBST_ID_W       32
`define SBST_BSR_W      109

// identification word layout
`define SBST_ID_REV_HI  31
`define SBST_ID_REV_LO  28
`define SBST_ID_PART_HI 27
`define SBST_ID_PART_LO 12
`define SBST_ID_MAKR_HI 11
`define SBST_ID_MAKR_LO 1
`define SBST_ID_FIX_BIT 0

// instruction codes
`define SBST_OP_EXTEST  3'h0
`define SBST_OP_IDCODE  3'h1
`define SBST_OP_SAMPZ   3'h2
`define SBST_OP_SAMPLE  3'h4
`define SBST_OP_BYPASS  3'h7

// value captured into the instruction shifter
`define SBST_IR_CAPT    3'h1

// boundary cell indices (cell n sits at bit n-1)
`define SBST_CELL_GND_A 47
`define SBST_CELL_GND_B 63
`define SBST_CELL_OCTL  108

`endif

// >>> rtl/sbst_pkg.sv
`include "sbst_defines.svh"

package sbst_pkg;

  // tap controller states, gray steps in the order listed
  typedef enum logic [3:0] {
    SBST_TLR   = 4'h0,
    SBST_RTI   = 4'h1,
    SBST_SELDR = 4'h3,
    SBST_CAPDR = 4'h2,
    SBST_SHDR  = 4'h6,
    SBST_EX1DR = 4'h7,
    SBST_PSDR  = 4'h5,
    SBST_EX2DR = 4'h4,
    SBST_UPDR  = 4'hC,
    SBST_SELIR = 4'hD,
    SBST_CAPIR = 4'hF,
    SBST_SHIR  = 4'hE,
    SBST_EX1IR = 4'hA,
    SBST_PSIR  = 4'hB,
    SBST_EX2IR = 4'h9,
    SBST_UPIR  = 4'h8
  } sbst_state_t;

  // how each output pin group is sourced
  typedef struct packed {
    logic cq_upd;   // clock echo pins take update cells
    logic cq_hiz;   // clock echo pins float
    logic q_upd;    // data pins take update cells
    logic q_hiz;    // data pins float
  } sbst_pin_mode_t;

  // whole state of the tap
  typedef struct packed {
    sbst_state_t               st;
    logic [`SBST_IR_W-1:0]     ir_sh;
    logic [`SBST_IR_W-1:0]     ir;
    logic [`SBST_BSR_W-1:0]    dr_sh;
    logic [`SBST_BSR_W-1:0]    bsr_upd;
    logic                      tck_prev;
    logic                      tdo;
    logic                      tdo_oe_n;
    sbst_pin_mode_t            mode;
  } sbst_regs_t;

endpackage

// >>> rtl/sbst_sync.sv
`timescale 1ns/1ps

module sbst_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rstn,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  // --------------------------------------------------------------
  // two-stage synchroniser
  // --------------------------------------------------------------
  // first stage feeds only the second
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rstn)
    begin
      meta_r <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule // sbst_sync

// >>> rtl/sbst_tap.sv
// Function
// - 3/1/32/109-bit registers between serial pins
// - id: revision, part, maker, fixed one
// - cells 48 and 64 always capture low
// - extest drives output cells onto pins
// - extest captures input pin levels
// - extest in update-ir enables drivers
// - idcode loads fixed id on capture
// - idcode shifts id register in shift-dr
// - idcode current after reset or power-up
// - cell 109 gates data output drive
// - five tms-high edges reach reset state
// - serial output changes on falling edge
`timescale 1ns/1ps
`include "sbst_defines.svh"

module sbst_tap #(
  parameter logic [3:0]  ID_REV   = 4'h1,      // arbitrary value
  parameter logic [15:0] ID_PART  = 16'h0abc,  // arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h055    // arbitrary value
) (
  // clock and reset
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rstn,
  // test port pins, asynchronous
  input  wire logic                    i_tck,
  input  wire logic                    i_tms,
  input  wire logic                    i_tdi,
  output logic                         o_tdo,
  output logic                         o_tdo_oe_n,
  // pad ring, asynchronous levels in
  input  wire logic [`SBST_BSR_W-1:0]  i_pad_lvl,
  // pad ring control
  output logic [`SBST_BSR_W-1:0]       o_bsr_upd,
  output sbst_pkg::sbst_pin_mode_t     o_pin_mode,
  output logic [`SBST_IR_W-1:0]        o_instr
);

  sbst_pkg::sbst_regs_t     r_r;
  sbst_pkg::sbst_regs_t     r_nxt;
  logic [2:0]               jtag_s;
  logic [`SBST_BSR_W-1:0]   pad_s;
  logic                     tck_s;
  logic                     tms_s;
  logic                     tdi_s;
  logic                     tck_rise;
  logic                     tck_fall;
  logic [`SBST_ID_W-1:0]    id_word;
  logic [`SBST_BSR_W-1:0]   capt_bsr;
  logic                     sel_bsr;
  logic                     sel_id;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  sbst_sync #(.W(3)) u_sync_jtag (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_async   ({i_tck, i_tms, i_tdi}),
    .o_sync    (jtag_s)
  );

  // pad capture may see transitions; only repeatable when pads are stable
  sbst_sync #(.W(`SBST_BSR_W)) u_sync_pad (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_pad_lvl),
    .o_sync    (pad_s)
  );

  // ----------------------------------------------------------------
  // edge detect and fixed words
  // ----------------------------------------------------------------
  // tck is slow (>=50 ns) so system clock resolves each edge
  assign tck_s    = jtag_s[2];
  assign tms_s    = jtag_s[1];
  assign tdi_s    = jtag_s[0];
  assign tck_rise = tck_s & ~r_r.tck_prev;
  assign tck_fall = ~tck_s & r_r.tck_prev;

  // id rom contents
  always_comb
  begin
    id_word = '0;
    id_word[`SBST_ID_REV_HI:`SBST_ID_REV_LO]   = ID_REV;
    id_word[`SBST_ID_PART_HI:`SBST_ID_PART_LO] = ID_PART;
    id_word[`SBST_ID_MAKR_HI:`SBST_ID_MAKR_LO] = ID_MAKER;
    id_word[`SBST_ID_FIX_BIT]                  = 1'b1;
  end

  // boundary capture: pad levels, ground cells low, control cell kept
  always_comb
  begin
    capt_bsr                   = pad_s;
    capt_bsr[`SBST_CELL_GND_A] = 1'b0;
    capt_bsr[`SBST_CELL_GND_B] = 1'b0;
    capt_bsr[`SBST_CELL_OCTL]  = r_r.bsr_upd[`SBST_CELL_OCTL];
  end

  // data register selection; reserved codes fall back to bypass
  assign sel_bsr = (r_r.ir == `SBST_OP_EXTEST) || (r_r.ir == `SBST_OP_SAMPLE)
                || (r_r.ir == `SBST_OP_SAMPZ);
  assign sel_id  = (r_r.ir == `SBST_OP_IDCODE);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_nxt          = r_r;
    r_nxt.tck_prev = tck_s;

    // controller steps on rising tck
    if (tck_rise)
    begin
      unique case (r_r.st)
        sbst_pkg::SBST_TLR:   r_nxt.st = tms_s ? sbst_pkg::SBST_TLR   : sbst_pkg::SBST_RTI;
        sbst_pkg::SBST_RTI:   r_nxt.st = tms_s ? sbst_pkg::SBST_SELDR : sbst_pkg::SBST_RTI;
        sbst_pkg::SBST_SELDR: r_nxt.st = tms_s ? sbst_pkg::SBST_SELIR : sbst_pkg::SBST_CAPDR;
        sbst_pkg::SBST_CAPDR: r_nxt.st = tms_s ? sbst_pkg::SBST_EX1DR : sbst_pkg::SBST_SHDR;
        sbst_pkg::SBST_SHDR:  r_nxt.st = tms_s ? sbst_pkg::SBST_EX1DR : sbst_pkg::SBST_SHDR;
        sbst_pkg::SBST_EX1DR: r_nxt.st = tms_s ? sbst_pkg::SBST_UPDR  : sbst_pkg::SBST_PSDR;
        sbst_pkg::SBST_PSDR:  r_nxt.st = tms_s ? sbst_pkg::SBST_EX2DR : sbst_pkg::SBST_PSDR;
        sbst_pkg::SBST_EX2DR: r_nxt.st = tms_s ? sbst_pkg::SBST_UPDR  : sbst_pkg::SBST_SHDR;
        sbst_pkg::SBST_UPDR:  r_nxt.st = tms_s ? sbst_pkg::SBST_SELDR : sbst_pkg::SBST_RTI;
        sbst_pkg::SBST_SELIR: r_nxt.st = tms_s ? sbst_pkg::SBST_TLR   : sbst_pkg::SBST_CAPIR;
        sbst_pkg::SBST_CAPIR: r_nxt.st = tms_s ? sbst_pkg::SBST_EX1IR : sbst_pkg::SBST_SHIR;
        sbst_pkg::SBST_SHIR:  r_nxt.st = tms_s ? sbst_pkg::SBST_EX1IR : sbst_pkg::SBST_SHIR;
        sbst_pkg::SBST_EX1IR: r_nxt.st = tms_s ? sbst_pkg::SBST_UPIR  : sbst_pkg::SBST_PSIR;
        sbst_pkg::SBST_PSIR:  r_nxt.st = tms_s ? sbst_pkg::SBST_EX2IR : sbst_pkg::SBST_PSIR;
        sbst_pkg::SBST_EX2IR: r_nxt.st = tms_s ? sbst_pkg::SBST_UPIR  : sbst_pkg::SBST_SHIR;
        sbst_pkg::SBST_UPIR:  r_nxt.st = tms_s ? sbst_pkg::SBST_SELDR : sbst_pkg::SBST_RTI;
      endcase

      // reset state parks the default instruction at once, so pins let go
      if (r_nxt.st == sbst_pkg::SBST_TLR)
        r_nxt.ir = `SBST_OP_IDCODE;

      // actions belong to the state being left on this edge
      unique case (r_r.st)
        sbst_pkg::SBST_TLR:
        begin
          r_nxt.ir = `SBST_OP_IDCODE;
        end
        sbst_pkg::SBST_CAPIR:
        begin
          r_nxt.ir_sh = `SBST_IR_CAPT;
        end
        sbst_pkg::SBST_SHIR:
        begin
          r_nxt.ir_sh = {tdi_s, r_r.ir_sh[`SBST_IR_W-1:1]};
        end
        sbst_pkg::SBST_UPIR:
        begin
          r_nxt.ir = r_r.ir_sh;
        end
        sbst_pkg::SBST_CAPDR:
        begin
          if (sel_id)
            r_nxt.dr_sh[`SBST_ID_W-1:0] = id_word;
          else if (sel_bsr)
            r_nxt.dr_sh = capt_bsr;
          else
            r_nxt.dr_sh[0] = 1'b0;
        end
        sbst_pkg::SBST_SHDR:
        begin
          if (sel_bsr)
            r_nxt.dr_sh = {tdi_s, r_r.dr_sh[`SBST_BSR_W-1:1]};
          else if (sel_id)
            r_nxt.dr_sh[`SBST_ID_W-1:0] = {tdi_s, r_r.dr_sh[`SBST_ID_W-1:1]};
          else
            r_nxt.dr_sh[0] = tdi_s;
        end
        sbst_pkg::SBST_UPDR:
        begin
          if (r_r.ir == `SBST_OP_EXTEST || r_r.ir == `SBST_OP_SAMPLE)
            r_nxt.bsr_upd = r_r.dr_sh;
        end
        default:
        begin
          r_nxt.ir_sh = r_r.ir_sh;
        end
      endcase
    end

    // serial output moves only on falling tck
    if (tck_fall)
    begin
      r_nxt.tdo      = (r_r.st == sbst_pkg::SBST_SHIR) ? r_r.ir_sh[0] : r_r.dr_sh[0];
      r_nxt.tdo_oe_n = !((r_r.st == sbst_pkg::SBST_SHIR)
                      || (r_r.st == sbst_pkg::SBST_SHDR));
    end

    // pin sourcing follows current instruction and control cell
    r_nxt.mode = '0;
    if (r_r.ir == `SBST_OP_EXTEST)
    begin
      r_nxt.mode.cq_upd = 1'b1;
      r_nxt.mode.q_upd  = r_r.bsr_upd[`SBST_CELL_OCTL];
      r_nxt.mode.q_hiz  = !r_r.bsr_upd[`SBST_CELL_OCTL];
    end
    else if (r_r.ir == `SBST_OP_SAMPZ)
    begin
      r_nxt.mode.cq_hiz = 1'b1;
      r_nxt.mode.q_hiz  = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset stands in for power-up: reset state, idcode current
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rstn)
    begin
      r_r          <= '0;
      r_r.st       <= sbst_pkg::SBST_TLR;
      r_r.ir       <= `SBST_OP_IDCODE;
      r_r.ir_sh    <= `SBST_IR_CAPT;
      r_r.tdo_oe_n <= 1'b1;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from flops
  assign o_tdo      = r_r.tdo;
  assign o_tdo_oe_n = r_r.tdo_oe_n;
  assign o_bsr_upd  = r_r.bsr_upd;
  assign o_pin_mode = r_r.mode;
  assign o_instr    = r_r.ir;

endmodule // sbst_tap

// >>> testbench/sbst_tap_props.sv
`timescale 1ns/1ps
`include "sbst_defines.svh"

// ----------------
// port properties
// ----------------
module sbst_props (
  // clock and reset
  input wire logic                     i_sys_clk,
  input wire logic                     i_rstn,
  // watched pins
  input wire logic                     i_tck,
  input wire logic                     o_tdo,
  input wire logic                     o_tdo_oe_n,
  input wire logic [`SBST_BSR_W-1:0]   o_bsr_upd,
  input wire sbst_pkg::sbst_pin_mode_t o_pin_mode,
  input wire logic [`SBST_IR_W-1:0]    o_instr
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  // tck edges are seen through synchronisers, so each output lags its edge
  reset_vals_a: assert property ($rose(i_rstn) |-> o_instr == `SBST_OP_IDCODE
    && o_tdo_oe_n && o_bsr_upd == '0 && o_pin_mode == '0) else $error("bad reset values");
  tdo_fall_a: assert property ($changed(o_tdo) |-> !i_tck && !$past(i_tck, 2))
    else $error("tdo moved outside tck low");
  oe_fall_a: assert property ($changed(o_tdo_oe_n) |-> !i_tck)
    else $error("tdo enable moved outside tck low");
  instr_rise_a: assert property ($changed(o_instr) |-> i_tck)
    else $error("instruction moved outside tck high");
  cell_update_a: assert property ($changed(o_bsr_upd) |-> i_tck
    && (o_instr == `SBST_OP_EXTEST || o_instr == `SBST_OP_SAMPLE)) else $error("bad cell update");
  extest_pins_a: assert property (o_instr == `SBST_OP_EXTEST && $stable(o_instr)
    && $stable(o_bsr_upd[`SBST_CELL_OCTL]) |-> o_pin_mode == {2'b10,
    o_bsr_upd[`SBST_CELL_OCTL], !o_bsr_upd[`SBST_CELL_OCTL]}) else $error("bad extest pins");
  ram_pins_a: assert property (o_instr != `SBST_OP_EXTEST && o_instr != `SBST_OP_SAMPZ
    && $stable(o_instr) |-> o_pin_mode == '0) else $error("pins not left to the ram");
  float_pins_a: assert property (o_instr == `SBST_OP_SAMPZ && $stable(o_instr)
    |-> o_pin_mode == 4'h5) else $error("pins not floating");
  cover property (o_instr == `SBST_OP_EXTEST && o_pin_mode.q_upd);
  cover property ($fell(o_tdo_oe_n));
  cover property ($changed(o_bsr_upd));
endmodule // sbst_props

bind sbst_tap sbst_props u_props (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_tck(i_tck),
  .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n), .o_bsr_upd(o_bsr_upd), .o_pin_mode(o_pin_mode),
  .o_instr(o_instr));

// >>> testbench/sbst_ctl_model.sv
`timescale 1ns/1ps

// ----------------
// test controller
// ----------------
module sbst_ctl_model (
  // system clock, only to place tck edges
  input  wire logic i_sys_clk,
  // serial test pins
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo
);
  logic b;

  // tck rests low between frames
  initial
  begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end

  // one 125 ns period; tdo read just before the rise
  task automatic step(input logic tms, input logic tdi);
    o_tms = tms;
    o_tdi = tdi;
    #62.5 b = i_tdo;
    o_tck = 1'b1;
    #62.5 o_tck = 1'b0;
  endtask

  // frames start 1 ns past a falling system edge: with 62.5 ns halves
  // no tck edge then lands on a rising system edge
  task automatic align;
    @(negedge i_sys_clk);
    #1;
  endtask

  // five high mode-select edges, then idle
  task automatic reset5;
    align;
    repeat (5) step(1'b1, ~o_tdi);
    step(1'b0, ~o_tdi);
  endtask

  // idle to idle scan, lsb first; tdi toggles when unused
  task automatic scan(input logic ir, input int n, input logic [108:0] din,
                      output logic [108:0] dout);
    dout = '0;
    align;
    step(1'b1, ~o_tdi);
    if (ir)
      step(1'b1, ~o_tdi);
    step(1'b0, ~o_tdi);
    step(1'b0, ~o_tdi);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i]);
      dout[i] = b;
    end
    step(1'b1, ~o_tdi);
    step(1'b0, ~o_tdi);
    #50; // outputs lag the update edge by a few system clocks
  endtask
endmodule // sbst_ctl_model

// >>> testbench/tb_sram_boundary_scan_tap.sv
`timescale 1ns/1ps
`include "sbst_defines.svh"

// ----------
// tap bench
// ----------
module tb_sram_boundary_scan_tap;
  localparam logic [3:0]   REV   = 4'h3;     // arbitrary value
  localparam logic [15:0]  PART  = 16'h1234; // arbitrary value
  localparam logic [10:0]  MAKER = 11'h2a5;  // arbitrary value
  localparam logic [108:0] PADS  = {1'b1, {27{4'ha}}};
  localparam logic [108:0] VEC   = {1'b1, {27{4'h3}}};

  logic                     i_sys_clk = 1'b0;
  logic                     i_rstn    = 1'b0;
  logic                     tck;
  logic                     tms;
  logic                     tdi;
  logic                     o_tdo;
  logic                     o_tdo_oe_n;
  logic [108:0]             pads      = '0;
  logic [108:0]             bsr;
  sbst_pkg::sbst_pin_mode_t pmode;
  logic [2:0]               instr;
  logic [108:0]             got;
  int                       failures  = 0;
  int                       checked   = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  sbst_ctl_model ctl (.i_sys_clk(i_sys_clk), .o_tck(tck), .o_tms(tms), .o_tdi(tdi),
    .i_tdo(o_tdo));

  sbst_tap #(.ID_REV(REV), .ID_PART(PART), .ID_MAKER(MAKER)) dut (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n), .i_pad_lvl(pads), .o_bsr_upd(bsr),
    .o_pin_mode(pmode), .o_instr(instr));

  task automatic cmp(input logic [108:0] g, input logic [108:0] e, input string what);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  task automatic wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // id word read straight after reset
  task automatic t_idcode;
    ctl.scan(1'b0, 32, '0, got);
    cmp(got[31:0], {REV, PART, MAKER, 1'b1}, "id word");
    cmp(instr, `SBST_OP_IDCODE, "default instruction");
  endtask

  // ir capture pattern, then one-bit delay through bypass
  task automatic t_bypass;
    ctl.scan(1'b1, 3, `SBST_OP_BYPASS, got);
    cmp(got[2:0], `SBST_IR_CAPT, "ir capture");
    ctl.scan(1'b0, 8, 8'hb5, got);
    cmp(got[7:0], 8'h6a, "bypass delay");
    cmp(o_tdo_oe_n, 1'b1, "tdo released in idle");
  endtask

  // preload, switch to extest, then capture the pads under extest
  task automatic t_extest;
    logic [108:0] e;
    @(negedge i_sys_clk) pads = PADS;
    e = PADS;
    e[`SBST_CELL_GND_A] = 1'b0;
    e[`SBST_CELL_GND_B] = 1'b0;
    e[`SBST_CELL_OCTL] = 1'b0;
    ctl.scan(1'b1, 3, `SBST_OP_SAMPLE, got);
    ctl.scan(1'b0, 109, VEC, got);
    cmp(got, e, "sample capture");
    cmp(bsr, VEC, "preloaded cells");
    ctl.scan(1'b1, 3, `SBST_OP_EXTEST, got);
    cmp(pmode, 4'ha, "extest drive on");
    @(negedge i_sys_clk) pads = ~PADS;
    e = ~PADS;
    e[`SBST_CELL_GND_A] = 1'b0;
    e[`SBST_CELL_GND_B] = 1'b0;
    e[`SBST_CELL_OCTL] = VEC[108];
    ctl.scan(1'b0, 109, ~VEC, got);
    cmp(got, e, "extest capture");
    cmp(bsr, ~VEC, "extest cells");
    cmp(pmode, 4'h9, "control cell floats data");
  endtask

  // every public code scanned in, only bypass checked as loaded; reserved codes stay unused
  task automatic t_codes;
    logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
    foreach (codes[i])
      ctl.scan(1'b1, 3, codes[i], got);
    cmp(instr, `SBST_OP_BYPASS, "last instruction");
    cmp(pmode, 4'h0, "pins left to the ram");
  endtask

  // mode-select reset from extest, then a mid-run reset
  task automatic t_resets;
    ctl.scan(1'b1, 3, `SBST_OP_EXTEST, got);
    ctl.reset5;
    #50;
    cmp(instr, `SBST_OP_IDCODE, "mode-select reset");
    cmp(pmode, 4'h0, "pins released");
    ctl.scan(1'b1, 3, `SBST_OP_SAMPLE, got);
    @(negedge i_sys_clk) i_rstn = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    cmp(instr, `SBST_OP_IDCODE, "power-up reset");
    cmp(bsr, '0, "cells cleared");
    ctl.reset5;
    t_idcode;
  endtask

  // main sequence
  initial
  begin
    repeat (4) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    ctl.reset5;
    t_idcode;
    t_bypass;
    t_extest;
    t_codes;
    t_resets;
    wrap_up;
  end

  // watchdog, well past the expected run length
  initial
  begin
    #400_000;
    failures++;
    wrap_up;
  end
endmodule // tb_sram_boundary_scan_tap
